// ---- hw/cer_consts.svh ----
`ifndef CER_CONSTS_SVH
`define CER_CONSTS_SVH

// Register byte offsets on the APB
`define CER_OFS_STATUS 8'h00
`define CER_OFS_VBASE 8'h04
`define CER_OFS_EVENT 8'h08
`define CER_OFS_VADDR 8'h0C

// Status word field positions and register reset values
`define CER_SR_TRACE_HI 15
`define CER_SR_TRACE_LO 14
`define CER_SR_SUPER 13
`define CER_SR_MASK_HI 10
`define CER_SR_MASK_LO 8
`define CER_SR_RESET 16'h2700
`define CER_VBASE_RESET 32'h0000_0000

// Trace select encodings
`define CER_TRACE_NONE 2'b00
`define CER_TRACE_FLOW 2'b01
`define CER_TRACE_ALL 2'b10

// Vector numbers
`define CER_VEC_PRIV 8'h08
`define CER_VEC_ALINE 8'h0A
`define CER_VEC_FLINE 8'h0B
`define CER_VEC_BKPT 8'h0C
`define CER_VEC_FORMAT 8'h0E
`define CER_VEC_SPURIOUS 8'h18

// Opcode patterns and the non-maskable interrupt level
`define CER_OP_ILLEGAL 16'h4AFC
`define CER_LINE_A 4'hA
`define CER_LINE_F 4'hF
`define CER_LEVEL_NMI 3'h7

`endif

// ---- hw/cer_pkg.sv ----
package cer_pkg;

	typedef enum logic [1:0] {
		CER_IDLE = 2'b01,
		CER_IACK = 2'b10
	} cer_state_type;

	typedef struct packed {
		cer_state_type st;
		logic [7:1] sync1;
		logic [7:1] sync2;
		logic [7:1] samp;
		logic [7:1] req;
		logic [15:0] status;
		logic [31:0] vbase;
		logic [1:0] trace_start;
		logic forced_pend;
		logic [7:0] forced_vec;
		logic trace_pend;
		logic trace_defer;
		logic bkpt_pend;
		logic exc_valid;
		logic [7:0] exc_vector;
		logic [31:0] exc_addr;
		logic exc_pc_instr;
		logic decode_abort;
		logic stop_inhibit;
		logic iack_req;
		logic [2:0] iack_level;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} cer_regs_type;

endpackage : cer_pkg

// ---- hw/cer_exception_unit.sv ----
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "cer_consts.svh"

module cer_exception_unit #(
	parameter logic [7:0] ILLEGAL_VECTOR = 8'h04,
	parameter logic [7:0] TRACE_VECTOR = 8'h09,
	parameter logic [3:0] FMT_FOUR = 4'h0,
	parameter logic [3:0] FMT_SIX = 4'h2,
	parameter logic [3:0] FMT_FAULT = 4'hC,
	// Arbitrary value
	parameter logic [7:0] CORE_VERSION = 8'h5A
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [7:1] level_request_lines_n,
	input wire logic dec_valid,
	input wire logic [15:0] dec_opcode,
	input wire logic [15:0] dec_ext,
	input wire logic dec_ext_is_index,
	input wire logic dec_no_match,
	input wire logic dec_ctrl_undefined,
	input wire logic dec_fline_unimpl,
	input wire logic dec_privileged,
	input wire logic rte_check,
	input wire logic [3:0] rte_format,
	input wire logic [7:0] rte_version,
	input wire logic instr_done,
	input wire logic done_flow_change,
	input wire logic done_fault_abort,
	input wire logic done_rte_fault,
	input wire logic done_is_stop,
	input wire logic trap_forced,
	input wire logic [7:0] trap_vector,
	input wire logic bkpt_request,
	input wire logic core_boundary,
	input wire logic iack_done,
	input wire logic iack_autovec,
	input wire logic iack_berr,
	input wire logic [7:0] iack_vector,
	output logic exc_valid,
	output logic [7:0] exc_vector,
	output logic [31:0] exc_addr,
	output logic exc_pc_instr,
	output logic decode_abort,
	output logic stop_inhibit,
	output logic iack_req,
	output logic [2:0] iack_level,
	output logic [15:0] status_word
);

	cer_pkg::cer_regs_type r;
	cer_pkg::cer_regs_type next_r;

	// Highest active request; 0 means nothing requested
	function automatic logic [2:0] cer_level(input logic [7:1] req);
		logic [2:0] lvl;
		lvl = 3'h0;
		for (int i = 1; i <= 7; i++) begin
			if (req[i]) begin
				lvl = 3'(i);
			end
		end
		return lvl;
	endfunction : cer_level

	function automatic logic [31:0] cer_vaddr(input logic [31:0] base, input logic [7:0] vec);
		return base + {22'h00_0000, vec, 2'b00};
	endfunction : cer_vaddr

	logic [2:0] req_level;
	logic irq_ok;
	logic idx_bad;
	logic frame_bad;
	logic trace_hit;
	logic stop_trace;
	logic wr_go;
	logic dec_fault;

	always_comb begin
		req_level = cer_level(r.req);
		irq_ok = (req_level == `CER_LEVEL_NMI) ||
			(req_level != 3'h0 && req_level > r.status[`CER_SR_MASK_HI:`CER_SR_MASK_LO]);
		idx_bad = dec_ext_is_index && (dec_ext[5:4] == 2'b00 || dec_ext[3:0] != 4'h0);
		// One flag, so a clean decode never touches a pending forced exception
		dec_fault = dec_opcode == `CER_OP_ILLEGAL || dec_opcode[15:12] == `CER_LINE_A ||
			(dec_opcode[15:12] == `CER_LINE_F && dec_fline_unimpl) || dec_no_match ||
			dec_ctrl_undefined || idx_bad || (dec_privileged && !r.status[`CER_SR_SUPER]);
		frame_bad = !(rte_format == FMT_FOUR || rte_format == FMT_SIX ||
			(rte_format == FMT_FAULT && rte_version == CORE_VERSION));
		trace_hit = (r.trace_start == `CER_TRACE_FLOW && done_flow_change) ||
			r.trace_start == `CER_TRACE_ALL;
		stop_trace = done_is_stop && r.trace_start[1];
		wr_go = psel && penable && r.pready && pwrite;
	end

	always_comb begin
		next_r = r;
		next_r.exc_valid = 1'b0;
		next_r.iack_req = 1'b0;
		next_r.decode_abort = 1'b0;
		next_r.stop_inhibit = 1'b0;

		// Second flop and sampler read the synchroniser; first flop feeds nothing else
		next_r.sync1 = level_request_lines_n;
		next_r.sync2 = r.sync1;
		next_r.samp = r.sync2;
		if (r.sync2 == r.samp) begin
			next_r.req = ~r.samp;
		end

		// APB: answer in the cycle after setup, so no wait states
		next_r.pready = psel && !penable;
		next_r.pslverr = 1'b0;
		next_r.prdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				`CER_OFS_STATUS: next_r.prdata = {16'h0000, r.status};
				`CER_OFS_VBASE: next_r.prdata = r.vbase;
				`CER_OFS_EVENT: next_r.prdata = {14'h0000, r.st, r.forced_pend, r.trace_pend,
					r.trace_defer, r.bkpt_pend, 1'b0, req_level, r.exc_vector};
				`CER_OFS_VADDR: next_r.prdata = r.exc_addr;
				default: next_r.pslverr = 1'b1;
			endcase
		end
		if (wr_go) begin
			case (paddr)
				`CER_OFS_STATUS: next_r.status = pwdata[15:0];
				`CER_OFS_VBASE: next_r.vbase = pwdata;
				default: next_r.status = r.status;
			endcase
		end

		// Exception selection; pending clears come first so a same-cycle set wins
		case (r.st)
			cer_pkg::CER_IDLE: begin
				if (core_boundary) begin
					if (r.forced_pend) begin
						next_r.forced_pend = 1'b0;
						next_r.exc_valid = 1'b1;
						next_r.exc_vector = r.forced_vec;
						next_r.exc_addr = cer_vaddr(r.vbase, r.forced_vec);
						next_r.exc_pc_instr = 1'b1;
						next_r.status[`CER_SR_SUPER] = 1'b1;
						next_r.status[`CER_SR_TRACE_HI:`CER_SR_TRACE_LO] = `CER_TRACE_NONE;
					end else if (r.trace_pend) begin
						next_r.trace_pend = 1'b0;
						next_r.exc_valid = 1'b1;
						next_r.exc_vector = TRACE_VECTOR;
						next_r.exc_addr = cer_vaddr(r.vbase, TRACE_VECTOR);
						next_r.exc_pc_instr = 1'b0;
						next_r.status[`CER_SR_SUPER] = 1'b1;
						next_r.status[`CER_SR_TRACE_HI:`CER_SR_TRACE_LO] = `CER_TRACE_NONE;
					end else if (irq_ok) begin
						next_r.iack_req = 1'b1;
						next_r.iack_level = req_level;
						next_r.status[`CER_SR_SUPER] = 1'b1;
						next_r.status[`CER_SR_TRACE_HI:`CER_SR_TRACE_LO] = `CER_TRACE_NONE;
						next_r.status[`CER_SR_MASK_HI:`CER_SR_MASK_LO] = req_level;
						next_r.st = cer_pkg::CER_IACK;
					end else if (r.bkpt_pend) begin
						next_r.bkpt_pend = 1'b0;
						next_r.exc_valid = 1'b1;
						next_r.exc_vector = `CER_VEC_BKPT;
						next_r.exc_addr = cer_vaddr(r.vbase, `CER_VEC_BKPT);
						next_r.exc_pc_instr = 1'b0;
						next_r.status[`CER_SR_SUPER] = 1'b1;
						next_r.status[`CER_SR_TRACE_HI:`CER_SR_TRACE_LO] = `CER_TRACE_NONE;
					end
				end
			end
			cer_pkg::CER_IACK: begin
				if (iack_done) begin
					next_r.exc_valid = 1'b1;
					next_r.exc_pc_instr = 1'b0;
					next_r.st = cer_pkg::CER_IDLE;
					if (iack_berr) begin
						next_r.exc_vector = `CER_VEC_SPURIOUS;
						next_r.exc_addr = cer_vaddr(r.vbase, `CER_VEC_SPURIOUS);
					end else if (iack_autovec) begin
						next_r.exc_vector = `CER_VEC_SPURIOUS + {5'h00, r.iack_level};
						next_r.exc_addr = cer_vaddr(r.vbase,
							`CER_VEC_SPURIOUS + {5'h00, r.iack_level});
					end else begin
						// Any of 256 vectors, covering the 192 user entries
						next_r.exc_vector = iack_vector;
						next_r.exc_addr = cer_vaddr(r.vbase, iack_vector);
					end
				end
			end
			default: next_r.st = cer_pkg::CER_IDLE;
		endcase

		// Decode faults stop the instruction before anything is written
		if (dec_valid) begin
			next_r.trace_start = r.status[`CER_SR_TRACE_HI:`CER_SR_TRACE_LO];
		end
		if (dec_valid && dec_fault) begin
			next_r.decode_abort = 1'b1;
			next_r.forced_pend = 1'b1;
			if (dec_opcode == `CER_OP_ILLEGAL) begin
				next_r.forced_vec = ILLEGAL_VECTOR;
			end else if (dec_opcode[15:12] == `CER_LINE_A) begin
				next_r.forced_vec = `CER_VEC_ALINE;
			end else if (dec_opcode[15:12] == `CER_LINE_F && dec_fline_unimpl) begin
				next_r.forced_vec = `CER_VEC_FLINE;
			end else if (dec_no_match || dec_ctrl_undefined || idx_bad) begin
				next_r.forced_vec = ILLEGAL_VECTOR;
			end else begin
				next_r.forced_vec = `CER_VEC_PRIV;
			end
		end

		if (rte_check && frame_bad) begin
			next_r.forced_pend = 1'b1;
			next_r.forced_vec = `CER_VEC_FORMAT;
		end
		if (trap_forced) begin
			next_r.forced_pend = 1'b1;
			next_r.forced_vec = trap_vector;
		end
		if (bkpt_request) begin
			next_r.bkpt_pend = 1'b1;
		end

		if (instr_done) begin
			if (done_fault_abort) begin
				next_r.trace_defer = r.trace_defer || trace_hit || stop_trace;
			end else if (!done_rte_fault) begin
				if (trace_hit || stop_trace || r.trace_defer) begin
					next_r.trace_pend = 1'b1;
					next_r.trace_defer = 1'b0;
				end
				next_r.stop_inhibit = stop_trace;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r <= '{st: cer_pkg::CER_IDLE, sync1: 7'h7F, sync2: 7'h7F, samp: 7'h7F,
				status: `CER_SR_RESET, vbase: `CER_VBASE_RESET, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign pready = r.pready;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign exc_valid = r.exc_valid;
	assign exc_vector = r.exc_vector;
	assign exc_addr = r.exc_addr;
	assign exc_pc_instr = r.exc_pc_instr;
	assign decode_abort = r.decode_abort;
	assign stop_inhibit = r.stop_inhibit;
	assign iack_req = r.iack_req;
	assign iack_level = r.iack_level;
	assign status_word = r.status;

	sequence s_iack_wait;
		r.st == cer_pkg::CER_IACK && iack_done && !iack_berr;
	endsequence

	sequence s_emit_vec(logic [7:0] v);
		r.exc_valid && r.exc_vector == v && r.exc_addr == $past(r.vbase) + {22'h0, v, 2'b00};
	endsequence

	property p_mask;
		@(posedge clock) disable iff (!reset_n)
		r.iack_req |-> r.iack_level == 3'h7 || r.iack_level > $past(r.status[10:8]);
	endproperty
	a_mask: assert property (p_mask) else $error("interrupt below mask taken");

	property p_nmi;
		@(posedge clock) disable iff (!reset_n)
		r.st == cer_pkg::CER_IDLE && core_boundary && !r.forced_pend && !r.trace_pend &&
			r.req[7] |=> r.iack_req && r.iack_level == 3'h7;
	endproperty
	a_nmi: assert property (p_nmi) else $error("level 7 not taken");

	property p_iack_sr;
		@(posedge clock) disable iff (!reset_n)
		r.iack_req |-> r.status[13] && r.status[15:14] == 2'b00 && r.status[10:8] == r.iack_level;
	endproperty
	a_iack_sr: assert property (p_iack_sr) else $error("status not updated on accept");

	property p_autovec;
		@(posedge clock) disable iff (!reset_n)
		s_iack_wait ##0 iack_autovec |=> s_emit_vec(8'd24 + {5'h0, $past(r.iack_level)});
	endproperty
	a_autovec: assert property (p_autovec) else $error("bad autovector");

	property p_spurious;
		@(posedge clock) disable iff (!reset_n)
		r.st == cer_pkg::CER_IACK && iack_done && iack_berr |=> s_emit_vec(8'd24);
	endproperty
	a_spurious: assert property (p_spurious) else $error("spurious vector wrong");

	property p_illegal;
		@(posedge clock) disable iff (!reset_n)
		dec_valid && dec_opcode == 16'h4AFC && !rte_check && !trap_forced |=>
			r.forced_pend && r.forced_vec == ILLEGAL_VECTOR && r.decode_abort;
	endproperty
	a_illegal: assert property (p_illegal) else $error("4AFC not illegal");

	property p_aline;
		@(posedge clock) disable iff (!reset_n)
		dec_valid && dec_opcode[15:12] == 4'hA && !rte_check && !trap_forced |=>
			(r.forced_pend && r.forced_vec == 8'd10 && r.decode_abort) and
			(r.st == cer_pkg::CER_IDLE && core_boundary |=> s_emit_vec(8'd10));
	endproperty
	a_aline: assert property (p_aline) else $error("A-line vector wrong");

	property p_priv;
		@(posedge clock) disable iff (!reset_n)
		dec_valid && dec_privileged && !r.status[13] && !dec_no_match && !dec_ctrl_undefined &&
			!idx_bad && dec_opcode[15:12] != 4'hA && dec_opcode[15:12] != 4'hF &&
			dec_opcode != 16'h4AFC && !rte_check && !trap_forced |=> r.forced_vec == 8'd8;
	endproperty
	a_priv: assert property (p_priv) else $error("privilege vector wrong");

	property p_format;
		@(posedge clock) disable iff (!reset_n)
		rte_check && frame_bad && !trap_forced |=> r.forced_pend && r.forced_vec == 8'd14;
	endproperty
	a_format: assert property (p_format) else $error("format error missed");

	property p_order;
		@(posedge clock) disable iff (!reset_n)
		r.st == cer_pkg::CER_IDLE && core_boundary && r.forced_pend && r.trace_pend |=>
			r.exc_valid && r.exc_vector == $past(r.forced_vec) && r.trace_pend;
	endproperty
	a_order: assert property (p_order) else $error("trace ahead of forced");

	property p_trace_off;
		@(posedge clock) disable iff (!reset_n)
		r.st == cer_pkg::CER_IDLE && core_boundary && !r.forced_pend && r.trace_pend |=>
			r.exc_vector == TRACE_VECTOR && !r.exc_pc_instr && r.status[15:14] == 2'b00;
	endproperty
	a_trace_off: assert property (p_trace_off) else $error("trace did not disable");

	property p_debounce;
		@(posedge clock) disable iff (!reset_n)
		r.req != $past(r.req) |-> $past(r.sync2) == $past(r.samp);
	endproperty
	a_debounce: assert property (p_debounce) else $error("request not debounced");

endmodule : cer_exception_unit

// ---- verification/cer_irq_peer.sv ----
`timescale 1ns/1ps
module cer_irq_peer #(
	parameter int ACK_WAIT = 6
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic raise,
	input wire logic [2:0] raise_level,
	input wire logic [1:0] ack_mode,
	input wire logic iack_req,
	input wire logic [2:0] iack_level,
	output logic [7:1] level_request_lines_n,
	output logic iack_done,
	output logic iack_autovec,
	output logic iack_berr,
	output logic [7:0] iack_vector
);
	logic [2:0] held;
	int wait_cnt;
	// Released lines return to the negated level
	always_comb begin
		level_request_lines_n = 7'h7F;
		if (held != 3'h0) level_request_lines_n[held] = 1'b0;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			held <= 3'h0;
			wait_cnt <= 0;
			iack_done <= 1'b0;
		end else begin
			iack_done <= 1'b0;
			if (raise) held <= raise_level;
			// Held until the matching acknowledge
			if (iack_req && iack_level == held && held != 3'h0) begin
				held <= 3'h0;
				wait_cnt <= ACK_WAIT;
			end
			if (wait_cnt > 0) begin
				wait_cnt <= wait_cnt - 1;
				if (wait_cnt == 1) iack_done <= 1'b1;
			end
		end
	end
	// Mode 0 autovector, 1 bus error, 2 supplied vector
	assign iack_autovec = ack_mode == 2'h0;
	assign iack_berr = ack_mode == 2'h1;
	assign iack_vector = 8'h40;
endmodule : cer_irq_peer

// ---- verification/tb_cpu_exception_recognition.sv ----
`timescale 1ns/1ps
`include "cer_consts.svh"
module tb_cpu_exception_recognition;
	localparam logic [31:0] VB = 32'h0000_1000;
	logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, trap_vector = 8'h00, iack_vector, exc_vector;
	logic [31:0] pwdata = 32'h0000_0000, prdata, exc_addr, q;
	logic [15:0] dec_opcode = 16'h0000, dec_ext = 16'h0000, status_word;
	logic dec_valid = 1'b0, dec_ext_is_index = 1'b0, dec_no_match = 1'b0;
	logic dec_ctrl_undefined = 1'b0, dec_fline_unimpl = 1'b0, dec_privileged = 1'b0;
	logic rte_check = 1'b0, instr_done = 1'b0, done_flow_change = 1'b0, trap_forced = 1'b0;
	logic [3:0] rte_format = 4'h0;
	logic [7:0] rte_version = 8'h00;
	logic raise = 1'b0;
	logic done_fault_abort = 1'b0, done_rte_fault = 1'b0, done_is_stop = 1'b0;
	logic bkpt_request = 1'b0, core_boundary = 1'b1;
	logic [2:0] raise_level = 3'h0, iack_level;
	logic [1:0] ack_mode = 2'h0;
	logic pready, pslverr, iack_done, iack_autovec, iack_berr, exc_valid, exc_pc_instr;
	logic decode_abort, stop_inhibit, iack_req, e;
	logic [7:1] level_request_lines_n;
	int err_total = 0, num_checks = 0, aborts = 0;

	always #4 clock = ~clock;
	always @(posedge clock) if (decode_abort === 1'b1) aborts++;

	cer_exception_unit dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .level_request_lines_n, .dec_valid, .dec_opcode, .dec_ext,
		.dec_ext_is_index, .dec_no_match, .dec_ctrl_undefined, .dec_fline_unimpl,
		.dec_privileged, .rte_check, .rte_format, .rte_version, .instr_done, .done_flow_change,
		.done_fault_abort, .done_rte_fault, .done_is_stop, .trap_forced,
		.trap_vector, .bkpt_request, .core_boundary, .iack_done, .iack_autovec,
		.iack_berr, .iack_vector, .exc_valid, .exc_vector, .exc_addr, .exc_pc_instr,
		.decode_abort, .stop_inhibit, .iack_req, .iack_level, .status_word);
	cer_irq_peer peer (.clock, .reset_n, .raise, .raise_level, .ack_mode, .iack_req,
		.iack_level, .level_request_lines_n, .iack_done, .iack_autovec, .iack_berr,
		.iack_vector);

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			report_and_stop();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_for(input int which);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while ((which ? iack_req : exc_valid) !== 1'b1 && n < 40);
		if (n >= 40) begin
			err_total++;
			report_and_stop();
		end
	endtask : wait_for
	task automatic none();
		logic seen;
		seen = 1'b0;
		repeat (12) @(posedge clock) if (exc_valid === 1'b1 || iack_req === 1'b1) seen = 1'b1;
		chk(seen, 0);
	endtask : none
	task automatic decode(input logic [15:0] op, input logic [4:0] f, input logic [15:0] x);
		@(posedge clock);
		dec_valid <= 1'b1;
		dec_opcode <= op;
		dec_ext <= x;
		{dec_ext_is_index, dec_privileged, dec_fline_unimpl, dec_ctrl_undefined, dec_no_match} <= f;
		@(posedge clock);
		dec_valid <= 1'b0;
		{dec_ext_is_index, dec_privileged, dec_fline_unimpl, dec_ctrl_undefined, dec_no_match} <= 5'h00;
	endtask : decode
	task automatic fault(input logic [15:0] op, input logic [4:0] f, input logic [15:0] x,
		input logic [7:0] v);
		int a0;
		a0 = aborts;
		decode(op, f, x);
		wait_for(0);
		chk(exc_vector, v);
		chk(exc_addr, VB + {22'h0, v, 2'b00});
		chk(exc_pc_instr, 1);
		chk(aborts - a0, 1);
	endtask : fault
	task automatic t_faults();
		fault(16'h4AFC, 5'h00, 16'h0000, 8'h04);
		fault(16'hA123, 5'h00, 16'h0000, `CER_VEC_ALINE);
		fault(16'hF200, 5'h04, 16'h0000, `CER_VEC_FLINE);
		fault(16'h0E00, 5'h01, 16'h0000, 8'h04);
		fault(16'h4E7B, 5'h02, 16'h0000, 8'h04);
		fault(16'h2030, 5'h10, 16'h0000, 8'h04);
		fault(16'h2030, 5'h10, 16'h0011, 8'h04);
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_0700);
		fault(16'h46FC, 5'h08, 16'h0000, `CER_VEC_PRIV);
		chk(status_word[13], 1);
	endtask : t_faults
	task automatic exception_return_instr(input logic [3:0] fmt, input logic [7:0] ver, input logic bad);
		@(posedge clock);
		rte_check <= 1'b1;
		rte_format <= fmt;
		rte_version <= ver;
		@(posedge clock);
		rte_check <= 1'b0;
		if (bad) begin
			wait_for(0);
			chk(exc_vector, `CER_VEC_FORMAT);
			chk(exc_pc_instr, 1);
		end else begin
			none();
		end
	endtask : exception_return_instr
	task automatic instr(input logic flow, input logic trap);
		decode(16'h4E71, 5'h00, 16'h0000);
		@(posedge clock);
		instr_done <= 1'b1;
		done_flow_change <= flow;
		trap_forced <= trap;
		trap_vector <= 8'h20;
		@(posedge clock);
		instr_done <= 1'b0;
		trap_forced <= 1'b0;
	endtask : instr
	task automatic trace_seen();
		wait_for(0);
		chk(exc_vector, 8'h09);
		chk(exc_pc_instr, 0);
		chk(status_word[15:14], 0);
	endtask : trace_seen
	task automatic t_trace();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_2700);
		instr(1'b1, 1'b0);
		none();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_6700);
		instr(1'b0, 1'b0);
		none();
		instr(1'b1, 1'b0);
		trace_seen();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_A700);
		instr(1'b0, 1'b0);
		trace_seen();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_A700);
		fault(16'hA000, 5'h00, 16'h0000, `CER_VEC_ALINE);
		none();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_A700);
		instr(1'b0, 1'b1);
		wait_for(0);
		chk(exc_vector, 8'h20);
		trace_seen();
	endtask : t_trace
	task automatic irq(input logic [2:0] l, input logic [1:0] m);
		@(posedge clock);
		raise <= 1'b1;
		raise_level <= l;
		ack_mode <= m;
		@(posedge clock);
		raise <= 1'b0;
	endtask : irq
	task automatic take(input logic [2:0] l, input logic [7:0] v);
		wait_for(1);
		chk(iack_level, l);
		wait_for(0);
		chk(exc_vector, v);
		chk(status_word, {3'h1, 2'h0, l, 8'h00});
	endtask : take
	task automatic t_irq();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_2700);
		irq(3'h5, 2'h0);
		none();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_A300);
		take(3'h5, 8'h1D);
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_2700);
		irq(3'h7, 2'h1);
		take(3'h7, `CER_VEC_SPURIOUS);
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_2000);
		irq(3'h1, 2'h2);
		take(3'h1, 8'h40);
		irq(3'h0, 2'h0);
		none();
	endtask : t_irq
	task automatic retire(input logic [3:0] k);
		@(posedge clock);
		instr_done <= 1'b1;
		{bkpt_request, done_is_stop, done_rte_fault, done_fault_abort} <= k;
		@(posedge clock);
		instr_done <= 1'b0;
		{bkpt_request, done_is_stop, done_rte_fault, done_fault_abort} <= 4'h0;
	endtask : retire
	task automatic t_more();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_A700);
		decode(16'h4E71, 5'h00, 16'h0000);
		retire(4'h1);
		none();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_2700);
		decode(16'h4E71, 5'h00, 16'h0000);
		retire(4'h0);
		trace_seen();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_A700);
		decode(16'h4E71, 5'h00, 16'h0000);
		retire(4'h2);
		none();
		decode(16'h4E71, 5'h00, 16'h0000);
		retire(4'h4);
		@(posedge clock);
		chk(stop_inhibit, 1);
		trace_seen();
		apb(1'b1, `CER_OFS_STATUS, 32'h0000_A700);
		decode(16'h4E71, 5'h00, 16'h0000);
		retire(4'h8);
		trace_seen();
		wait_for(0);
		chk(exc_vector, `CER_VEC_BKPT);
		core_boundary <= 1'b0;
		decode(16'h4AFC, 5'h00, 16'h0000);
		none();
		core_boundary <= 1'b1;
		wait_for(0);
		chk(exc_vector, 8'h04);
	endtask : t_more

	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		apb(1'b0, `CER_OFS_STATUS, 32'h0000_0000);
		chk(q, 32'h0000_2700);
		apb(1'b1, `CER_OFS_VBASE, VB);
		apb(1'b0, `CER_OFS_VBASE, 32'h0000_0000);
		chk(q, VB);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(e, 1);
		t_faults();
		exception_return_instr(4'h5, 8'h5A, 1'b1);
		exception_return_instr(4'hC, 8'h11, 1'b1);
		exception_return_instr(4'hC, 8'h5A, 1'b0);
		t_trace();
		t_irq();
		t_more();
		report_and_stop();
	end
endmodule : tb_cpu_exception_recognition
